// ===== hw/omc_ctrl.sv
// operating mode controller: idle, active and connected sequencing
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
//
// Overview of operation
// RL1: in idle the processor reference is the slow oscillator.
// RL2: in idle no data from the host is accepted.
// RL3: with power saving on, active falls to idle when nothing keeps it busy.
// RL4: power saving is off after reset until software turns it on.
// RL5: with flow control on, clear-to-send is on only in active with uart on.
// RL6: with flow control off, clear-to-send is held on in every mode.
// RL7: registered and power saving on, idle wakes at the paging period.
// RL8: unregistered and power saving on, idle wakes at the programmed period.
// RL9: an incoming call takes the module out of idle.
// RL10: a clock alarm takes the module out of idle.
// RL11: receive activity on the uart takes the module out of idle.
// RL12: in power saving setting 2, request-to-send on wakes idle to active.
// RL13: in active and connected the processor reference is the fast one.
// RL14: in active and connected the host interfaces accept data.
// RL15: a call holds connected mode and its end restores the earlier mode.
// RL16: the earlier mode is stored; reset starts in active, power saving off.
module omc_ctrl
  import omc_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // events from pins and other clock domains
  input  wire logic                  call_active,
  input  wire logic                  rtc_alarm,
  input  wire logic                  uart_rxd,
  input  wire logic                  uart_rts_n,
  input  wire logic                  net_registered,
  // paging period from the protocol logic, same clock (cycles)
  input  wire logic [OMC_TW-1:0]     paging_period,
  // mode outputs
  output logic                       ref_clk_fast,
  output logic                       host_data_accept,
  output logic                       uart_cts_n,
  output logic      [2:0]            op_mode
);

  // synchronised events
  omc_evt_t evt;
  omc_evt_t evt_raw;

  assign evt_raw = '{call:   call_active,
                     rtc:    rtc_alarm,
                     rxd:    uart_rxd,
                     rts_n:  uart_rts_n,
                     netreg: net_registered};

  omc_sync2 #(
    .W ($bits(omc_evt_t))
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (evt_raw),
    .sync_out (evt)
  );

  // ---------------- register bus ----------------

  omc_aphase_t ap_q, ap_d;
  omc_cfg_t    cfg_q, cfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status_w;

  // address decode for the read path
  function automatic logic is_mapped(input logic [7:0] a);
    if (a == OMC_CTRL_OFS) begin
      return 1'b1;
    end else if (a == OMC_IDLE_OFS) begin
      return 1'b1;
    end else if (a == OMC_DWELL_OFS) begin
      return 1'b1;
    end else if (a == OMC_STATUS_OFS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // read mux for one register offset
  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                          input omc_cfg_t c,
                                          input logic [31:0] st);
    logic [31:0] r;
    r = '0;
    if (a == OMC_CTRL_OFS) begin
      r[OMC_PSV_MSB:OMC_PSV_LSB] = c.psv;
      r[OMC_HWFC_BIT]            = c.hwfc;
      r[OMC_UARTEN_BIT]          = c.uart_en;
    end else if (a == OMC_IDLE_OFS) begin
      r[OMC_TW-1:0] = c.idle_per;
    end else if (a == OMC_DWELL_OFS) begin
      r[OMC_TW-1:0] = c.dwell;
    end else if (a == OMC_STATUS_OFS) begin
      r = st;
    end
    return r;
  endfunction

  // address phase capture, read data fetch and register writes
  always_comb begin
    logic take;
    take    = hsel && hready && (htrans == OMC_HTRANS_NONSEQ);
    ap_d    = ap_q;
    cfg_d   = cfg_q;
    rdata_d = rdata_q;
    if (hready) begin
      ap_d.valid = take;
      ap_d.write = hwrite;
      ap_d.addr  = haddr[7:0];
    end
    if (take && !hwrite && is_mapped(haddr[7:0])) begin
      rdata_d = reg_read(haddr[7:0], cfg_q, status_w);
    end else if (take && !hwrite) begin
      rdata_d = '0;  // unmapped reads as zero
    end
    if (ap_q.valid && ap_q.write) begin
      if (ap_q.addr == OMC_CTRL_OFS) begin
        cfg_d.psv     = hwdata[OMC_PSV_MSB:OMC_PSV_LSB];  // [RL4]
        cfg_d.hwfc    = hwdata[OMC_HWFC_BIT];
        cfg_d.uart_en = hwdata[OMC_UARTEN_BIT];
      end else if (ap_q.addr == OMC_IDLE_OFS) begin
        cfg_d.idle_per = hwdata[OMC_TW-1:0];
      end else if (ap_q.addr == OMC_DWELL_OFS) begin
        cfg_d.dwell = hwdata[OMC_TW-1:0];
      end
    end
  end

  // bus state; power saving starts off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_q          <= '0;
      cfg_q.psv     <= OMC_PSV_OFF;  // [RL4] [RL16]
      cfg_q.hwfc    <= OMC_HWFC_RST;
      cfg_q.uart_en <= OMC_UARTEN_RST;
      cfg_q.idle_per <= OMC_IDLE_RST;
      cfg_q.dwell   <= OMC_DWELL_RST;
      rdata_q       <= '0;
    end else begin
      ap_q    <= ap_d;
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = OMC_RESP_OKAY;
  assign hrdata    = rdata_q;

  // ---------------- event edges ----------------

  logic rx_prev_q, rtc_prev_q;
  logic rx_fall, rtc_rise, rts_on, psv_on;

  // previous synchronised levels for edge detection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_q  <= 1'b0;  // same as synchroniser reset, no false edge
      rtc_prev_q <= 1'b0;
    end else begin
      rx_prev_q  <= evt.rxd;
      rtc_prev_q <= evt.rtc;
    end
  end

  assign rx_fall  = rx_prev_q && !evt.rxd;  // start bit seen
  assign rtc_rise = evt.rtc && !rtc_prev_q;
  assign rts_on   = !evt.rts_n;
  assign psv_on   = (cfg_q.psv != OMC_PSV_OFF);

  // ---------------- mode sequencer ----------------

  omc_mode_t         mode_q, mode_d;
  omc_mode_t         saved_q, saved_d;
  logic [OMC_TW-1:0] tmr_q, tmr_d;
  logic [OMC_TW-1:0] wake_per;
  logic              wake_evt;

  // idle wake period: paging when registered, own period otherwise
  assign wake_per = evt.netreg ? paging_period     // [RL7]
                               : cfg_q.idle_per;   // [RL8]

  // events that end idle at once
  assign wake_evt = rtc_rise                       // [RL10]
                  | rx_fall                        // [RL11]
                  | ((cfg_q.psv == OMC_PSV_RTS) && rts_on);  // [RL12]

  // next mode, saved mode and dwell timer
  always_comb begin
    mode_d  = mode_q;
    saved_d = saved_q;
    tmr_d   = tmr_q;
    case (mode_q)
      MODE_IDLE: begin
        if (evt.call) begin
          mode_d  = MODE_CONN;  // [RL9] [RL15]
          saved_d = MODE_IDLE;  // [RL16]
          tmr_d   = OMC_TMR_ZERO;
        end else if (wake_evt) begin
          mode_d = MODE_ACTIVE;
          tmr_d  = OMC_TMR_ZERO;
        end else if (!psv_on) begin
          mode_d = MODE_ACTIVE;  // saving turned off while idle
          tmr_d  = OMC_TMR_ZERO;
        end else if (tmr_q + OMC_TMR_ONE >= wake_per) begin
          mode_d = MODE_ACTIVE;  // [RL7] [RL8]
          tmr_d  = OMC_TMR_ZERO;
        end else begin
          tmr_d = tmr_q + OMC_TMR_ONE;
        end
      end
      MODE_ACTIVE: begin
        if (evt.call) begin
          mode_d  = MODE_CONN;    // [RL15]
          saved_d = MODE_ACTIVE;  // [RL16]
          tmr_d   = OMC_TMR_ZERO;
        end else if (!psv_on || rx_fall) begin
          tmr_d = OMC_TMR_ZERO;  // [RL4] busy or saving off
        end else if (tmr_q + OMC_TMR_ONE >= cfg_q.dwell) begin
          mode_d = MODE_IDLE;  // [RL3]
          tmr_d  = OMC_TMR_ZERO;
        end else begin
          tmr_d = tmr_q + OMC_TMR_ONE;
        end
      end
      MODE_CONN: begin
        if (!evt.call) begin
          mode_d = saved_q;  // [RL15]
          tmr_d  = OMC_TMR_ZERO;
        end
      end
      default: begin
        mode_d = MODE_ACTIVE;
        tmr_d  = OMC_TMR_ZERO;
      end
    endcase
  end

  // sequencer state; starts active
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= MODE_ACTIVE;  // [RL16]
      saved_q <= MODE_ACTIVE;
      tmr_q   <= OMC_TMR_ZERO;
    end else begin
      mode_q  <= mode_d;
      saved_q <= saved_d;
      tmr_q   <= tmr_d;
    end
  end

  // ---------------- mode outputs ----------------

  logic fast_q, fast_d;
  logic acc_q, acc_d;
  logic cts_n_q, cts_n_d;

  // outputs follow the next mode so they align with mode_q
  always_comb begin
    fast_d  = (mode_d != MODE_IDLE);  // [RL1] [RL13]
    acc_d   = (mode_d != MODE_IDLE);  // [RL2] [RL14]
    if (!cfg_d.hwfc) begin
      cts_n_d = 1'b0;  // [RL6]
    end else begin
      cts_n_d = !((mode_d == MODE_ACTIVE) && cfg_d.uart_en);  // [RL5]
    end
  end

  // output flops; reset matches active mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_q  <= 1'b1;
      acc_q   <= 1'b1;
      cts_n_q <= 1'b0;
    end else begin
      fast_q  <= fast_d;
      acc_q   <= acc_d;
      cts_n_q <= cts_n_d;
    end
  end

  assign ref_clk_fast     = fast_q;
  assign host_data_accept = acc_q;
  assign uart_cts_n       = cts_n_q;
  assign op_mode          = mode_q;

  // status word
  always_comb begin
    status_w = '0;
    status_w[OMC_ST_MODE_MSB:OMC_ST_MODE_LSB] = mode_q;
    status_w[OMC_ST_SAVE_MSB:OMC_ST_SAVE_LSB] = saved_q;
    status_w[OMC_ST_REG_BIT]  = evt.netreg;
    status_w[OMC_ST_FAST_BIT] = fast_q;
    status_w[OMC_ST_CTS_BIT]  = cts_n_q;
    status_w[OMC_ST_ACC_BIT]  = acc_q;
  end

endmodule

// ===== hw/omc_pkg.sv
// shared constants and types for the operating mode controller
package omc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OMC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] OMC_IDLE_OFS   = 8'h04;
  localparam logic [7:0] OMC_DWELL_OFS  = 8'h08;
  localparam logic [7:0] OMC_STATUS_OFS = 8'h0c;

  // control register fields
  localparam int OMC_PSV_LSB   = 0;
  localparam int OMC_PSV_MSB   = 1;
  localparam int OMC_HWFC_BIT  = 2;
  localparam int OMC_UARTEN_BIT = 3;

  // status register fields
  localparam int OMC_ST_MODE_LSB  = 0;
  localparam int OMC_ST_MODE_MSB  = 2;
  localparam int OMC_ST_SAVE_LSB  = 3;
  localparam int OMC_ST_SAVE_MSB  = 5;
  localparam int OMC_ST_REG_BIT   = 6;
  localparam int OMC_ST_FAST_BIT  = 7;
  localparam int OMC_ST_CTS_BIT   = 8;
  localparam int OMC_ST_ACC_BIT   = 9;

  // power saving settings
  localparam logic [1:0] OMC_PSV_OFF = 2'h0;
  localparam logic [1:0] OMC_PSV_ON  = 2'h1;
  localparam logic [1:0] OMC_PSV_RTS = 2'h2;

  // timer width and reset values of the period registers (cycles)
  localparam int          OMC_TW          = 24;
  localparam logic [23:0] OMC_IDLE_RST    = 24'h0f4240;
  localparam logic [23:0] OMC_DWELL_RST   = 24'h00c350;
  localparam logic [23:0] OMC_TMR_ZERO    = 24'h000000;
  localparam logic [23:0] OMC_TMR_ONE     = 24'h000001;

  // reset values of control bits
  localparam logic       OMC_HWFC_RST   = 1'b1;
  localparam logic       OMC_UARTEN_RST = 1'b1;

  // ahb transfer type and response encodings
  localparam logic [1:0] OMC_HTRANS_NONSEQ = 2'h2;
  localparam logic       OMC_RESP_OKAY     = 1'b0;

  // operating modes
  typedef enum logic [2:0] {
    MODE_IDLE   = 3'b001,
    MODE_ACTIVE = 3'b010,
    MODE_CONN   = 3'b100
  } omc_mode_t;

  // latched address phase of one bus transfer
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } omc_aphase_t;

  // synchronised external event levels
  typedef struct packed {
    logic call;
    logic rtc;
    logic rxd;
    logic rts_n;
    logic netreg;
  } omc_evt_t;

  // software controls
  typedef struct packed {
    logic [1:0]  psv;
    logic        hwfc;
    logic        uart_en;
    logic [23:0] idle_per;
    logic [23:0] dwell;
  } omc_cfg_t;

endpackage

// ===== hw/omc_sync2.sv
// two flip-flop level synchroniser for a group of pins
`timescale 1ns/1ns
module omc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // asynchronous levels and their synchronised copies
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ===== verif/omc_ctrl_checker.sv
// port assertions for the mode controller
`timescale 1ns/1ns
module omc_ctrl_checker
  import omc_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // watched ports
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       call_active,
  input wire logic       rtc_alarm,
  input wire logic       uart_rxd,
  input wire logic       ref_clk_fast,
  input wire logic       host_data_accept,
  input wire logic [2:0] op_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_SLOW_IDLE: assert property (
    op_mode == MODE_IDLE |-> !ref_clk_fast)
    else $error("fast clock in idle");
  AST_FAST_AWAKE: assert property (
    op_mode != MODE_IDLE |-> ref_clk_fast)
    else $error("slow clock while awake");
  AST_ACCEPT: assert property (
    host_data_accept != (op_mode == MODE_IDLE))
    else $error("accept wrong for mode");
  AST_RESET_ACTIVE: assert property (
    $rose(rst_n) |-> op_mode == MODE_ACTIVE)
    else $error("not active after reset");
  AST_CALL_CONN: assert property (
    $rose(call_active) |-> ##[1:5] op_mode == MODE_CONN)
    else $error("call did not connect");
  AST_CALL_END: assert property (
    $fell(call_active) |-> ##[1:5] op_mode != MODE_CONN)
    else $error("call end kept connected");
  AST_RTC_WAKE: assert property (
    op_mode == MODE_IDLE && $rose(rtc_alarm)
      |-> ##[1:6] op_mode != MODE_IDLE)
    else $error("alarm did not wake");
  AST_RX_WAKE: assert property (
    op_mode == MODE_IDLE && $fell(uart_rxd)
      |-> ##[1:6] op_mode != MODE_IDLE)
    else $error("receive did not wake");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  // main scenarios
  cover property (op_mode == MODE_ACTIVE ##1 op_mode == MODE_IDLE);
  cover property (op_mode == MODE_IDLE ##1 op_mode == MODE_ACTIVE);
  cover property (op_mode == MODE_IDLE ##1 op_mode == MODE_CONN);
endmodule
bind omc_ctrl omc_ctrl_checker chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .hreadyout(hreadyout), .hresp(hresp), .call_active(call_active),
  .rtc_alarm(rtc_alarm), .uart_rxd(uart_rxd), .ref_clk_fast(ref_clk_fast),
  .host_data_accept(host_data_accept), .op_mode(op_mode));

// ===== verif/omc_ctrl_tb.sv
// self-checking bench for the operating mode controller
`timescale 1ns/1ns
module omc_ctrl_tb import omc_pkg::*; ();
  logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic call_active, rtc_alarm, send_rx, rts_on, net_registered;
  logic uart_rxd, uart_rts_n, ref_clk_fast, host_data_accept, uart_cts_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  op_mode;
  logic [23:0] paging_period;
  int mismatches = 0;
  int check_count = 0;
  int m_hwfc = 1; // model of the control bits
  int m_uen = 1;
  int n;
  int p;
  omc_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .call_active(call_active),
    .rtc_alarm(rtc_alarm), .uart_rxd(uart_rxd), .uart_rts_n(uart_rts_n),
    .net_registered(net_registered), .paging_period(paging_period),
    .ref_clk_fast(ref_clk_fast), .host_data_accept(host_data_accept),
    .uart_cts_n(uart_cts_n), .op_mode(op_mode));
  omc_host host_u (.core_clk(core_clk), .rst_n(rst_n), .send_rx(send_rx),
    .rts_on(rts_on), .uart_rxd(uart_rxd), .uart_rts_n(uart_rts_n));
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bad(input string w, input logic [31:0] e,
                     input logic [31:0] s);
    mismatches++;
    $display("BAD %s expected %h seen %h", w, e, s);
  endtask
  task automatic chk_reg(input string w, input logic [31:0] e);
    check_count++;
    if (rd !== e) bad(w, e, rd);
  endtask
  task automatic chk_rng(input string w, input int lo, input int hi);
    check_count++;
    if (n < lo || n > hi) bad(w, 32'(lo), 32'(n));
  endtask
  // mode outputs against the model for mode m
  task automatic chk_out(input logic [2:0] m);
    logic [5:0] e;
    check_count++;
    e = {m, m != MODE_IDLE, m != MODE_IDLE,
      !(m_hwfc == 0 || (m == MODE_ACTIVE && m_uen == 1))};
    if ({op_mode, ref_clk_fast, host_data_accept, uart_cts_n} !== e)
      bad("outputs", 32'(e),
        32'({op_mode, ref_clk_fast, host_data_accept, uart_cts_n}));
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (op_mode !== m && n < lim);
    if (op_mode !== m) begin
      bad("mode wait", 32'(m), 32'(op_mode));
      test_done();
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad("hready", 32'h1, 32'h0);
      test_done();
    end
  endtask
  // one single-word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= OMC_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    {rst_n, hsel, hwrite, call_active, rtc_alarm} = 5'h0;
    {send_rx, rts_on, net_registered} = 3'h0;
    {haddr, hwdata, htrans} = 66'h0;
    paging_period = 24'h000028;
    void'($urandom(67));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk_out(MODE_ACTIVE);
    ahb(0, OMC_CTRL_OFS, 0);
    chk_reg("ctrl", 32'h0000000c);
    ahb(0, OMC_IDLE_OFS, 0);
    chk_reg("idle", 32'(OMC_IDLE_RST));
    ahb(0, OMC_DWELL_OFS, 0);
    chk_reg("dwell", 32'(OMC_DWELL_RST));
    ahb(0, 8'h10, 0);
    chk_reg("unmapped", 32'h0);
    ahb(0, OMC_STATUS_OFS, 0);
    rd = rd & 32'h000003c7;
    chk_reg("status", 32'h00000282);
    ahb(1, OMC_DWELL_OFS, 20);
    ahb(1, OMC_IDLE_OFS, 30);
    repeat (60) @(negedge core_clk);
    chk_out(MODE_ACTIVE);
    ahb(1, OMC_CTRL_OFS, 32'h0d);
    wait_mode(MODE_IDLE, 200);
    chk_out(MODE_IDLE);
    wait_mode(MODE_ACTIVE, 200);
    chk_rng("idle wake", 28, 34);
    wait_mode(MODE_IDLE, 200);
    chk_rng("dwell", 18, 26);
    p = 40 + $urandom % 32;
    @(posedge core_clk);
    paging_period <= 24'(p);
    net_registered <= 1'b1;
    wait_mode(MODE_ACTIVE, 200);
    wait_mode(MODE_IDLE, 200);
    wait_mode(MODE_ACTIVE, 200);
    chk_rng("paging wake", p - 2, p + 4);
    @(posedge core_clk);
    net_registered <= 1'b0;
    ahb(1, OMC_IDLE_OFS, 32'h1000);
    // each wake event in turn: alarm, receive, request-to-send, call
    for (int e = 0; e < 4; e++) begin
      ahb(1, OMC_CTRL_OFS, e == 2 ? 32'h0e : 32'h0d);
      wait_mode(MODE_IDLE, 200);
      @(posedge core_clk);
      case (e)
        0: rtc_alarm <= 1'b1;
        1: send_rx <= 1'b1;
        2: rts_on <= 1'b1;
        default: call_active <= 1'b1;
      endcase
      wait_mode(e == 3 ? MODE_CONN : MODE_ACTIVE, 8);
      chk_out(e == 3 ? MODE_CONN : MODE_ACTIVE);
      @(posedge core_clk);
      {rtc_alarm, send_rx, rts_on, call_active} <= 4'h0;
    end
    wait_mode(MODE_IDLE, 8);
    chk_out(MODE_IDLE);
    ahb(1, OMC_CTRL_OFS, 32'h09);
    m_hwfc = 0;
    repeat (3) @(negedge core_clk);
    chk_out(MODE_IDLE);
    ahb(1, OMC_CTRL_OFS, 32'h04);
    m_hwfc = 1;
    m_uen = 0;
    wait_mode(MODE_ACTIVE, 8);
    chk_out(MODE_ACTIVE);
    @(posedge core_clk);
    call_active <= 1'b1;
    wait_mode(MODE_CONN, 8);
    chk_out(MODE_CONN);
    @(posedge core_clk);
    call_active <= 1'b0;
    wait_mode(MODE_ACTIVE, 8);
    chk_out(MODE_ACTIVE);
    test_done();
  end
endmodule

// ===== verif/omc_host.sv
// host model: uart receive line and request-to-send
`timescale 1ns/1ns
module omc_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // commands from the bench
  input wire logic send_rx,
  input wire logic rts_on,
  // lines toward the module
  output logic     uart_rxd,
  output logic     uart_rts_n
);
  logic [3:0] cnt_q;
  // a frame holds the receive line low for ten cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 4'h0;
    else if (send_rx && cnt_q == 4'h0) cnt_q <= 4'ha;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign uart_rxd   = (cnt_q == 4'h0); // idle high between frames
  assign uart_rts_n = !rts_on;         // low is on
endmodule
